// ===== rtl/fpcs_pkg.sv
// package of register offsets, fields, reset values and timing counts
package fpcs_pkg;
    localparam logic [4:0]  ADDR_NP_WORD   = 5'h08;
    localparam logic [4:0]  ADDR_EXT_CAP   = 5'h0f;
    localparam logic [4:0]  ADDR_LINK_CTRL = 5'h10;
    localparam int          ADDR_W         = 5;
    localparam int          DATA_W         = 16;
    // control register field positions
    localparam int          CTL_BLK_CEXT   = 13;
    localparam int          CTL_CRS_TX     = 11;
    localparam int          CTL_FORCE_LINK = 10;
    localparam int          CTL_RSVD9      = 9;
    localparam int          CTL_LB_TYPE    = 8;
    localparam int          CTL_RF_FAST    = 5;
    localparam int          CTL_RF_STD     = 4;
    localparam int          CTL_INT_POL    = 2;
    // writable-bit mask and hardware reset value of the control register
    localparam logic [15:0] CTL_WR_MASK    = 16'hfffc;
    localparam logic [15:0] CTL_RESET      = 16'h400c;
    // extended capability fields
    localparam int          EXT_X_FD       = 15;
    localparam int          EXT_X_HD       = 14;
    // mode encodings
    localparam logic [1:0]  MODE_100FX     = 2'h0;
    localparam logic [1:0]  MODE_1000X     = 2'h1;
    localparam logic [1:0]  MODE_SGMII_SYS = 2'h2;
    localparam logic [1:0]  MODE_SGMII_MED = 2'h3;
    // 8b/10b idle symbol that replaces carrier extension on the 8-bit receive path
    localparam logic [7:0]  RXD_IDLE       = 8'h00;
    // remote fault timing
    localparam int          CLK_MHZ        = 100;
    localparam int          RF_FAST_US     = 2000;
    localparam int          RF_STD_US      = 20000;
    localparam int          RF_FAST_CYC    = RF_FAST_US * CLK_MHZ;
    localparam int          RF_STD_CYC     = RF_STD_US * CLK_MHZ;
endpackage

// ===== rtl/fpcs_regs.sv
// fiber pcs next-page capture, extended capability and link control registers
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// R1: capture next page in 1000BASE-X mode only, clear on link drop
// R2: captured word maps received bits one-to-one
// R3: 1000BASE-X capability bits zero only in mode 00
// R4: 1000BASE-T capability and reserved bits read zero
// R5: block carrier extension to idle in full duplex
// R6: carrier sense on transmit, ignored in full duplex
// R7: force link bypasses link detection, link up
// R8: loopback type selects PCS or raw 10-bit
// R9: fast remote fault signalled within 2 ms
// R10: standard remote fault signalled after 20 ms
// R11: software sets at most one fault enable
// R12: interrupt polarity select, resets active low
// R13: mode field mirrors externally programmed fiber mode
// R14: software keeps reserved control bits at reset
// R15: load whole validated next page at once
module fpcs_regs #(
    parameter int RF_FAST_CYCLES = fpcs_pkg::RF_FAST_CYC,
    parameter int RF_STD_CYCLES  = fpcs_pkg::RF_STD_CYC
) (
    input  wire logic        SYS_CLK,
    input  wire logic        NRST,
    input  wire logic [4:0]  REG_ADDR,
    input  wire logic [15:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [15:0] REG_RDATA,
    input  wire logic [1:0]  FIBER_MODE,
    input  wire logic        AN_NP_VALID,
    input  wire logic [15:0] AN_NP_WORD,
    input  wire logic        LINK_RAW_UP,
    input  wire logic        FULL_DUPLEX,
    input  wire logic        TX_ACTIVE,
    input  wire logic        RX_ACTIVE,
    input  wire logic        RX_CEXT,
    input  wire logic [7:0]  RXD_IN,
    input  wire logic        RX_FAULT,
    input  wire logic        IRQ_EVENT,
    output logic      [7:0]  RXD_OUT,
    output logic             CRS_OUT,
    output logic             LINK_UP,
    output logic             LOOPBACK_RAW,
    output logic             REMOTE_FAULT_TX,
    output logic             IRQ_OUT_N
);
    typedef enum logic [2:0] {
        FPCS_RF_IDLE  = 3'h1,
        FPCS_RF_COUNT = 3'h2,
        FPCS_RF_SEND  = 3'h4
    } fpcs_rf_state_t;

    logic [15:0]    np_q;
    logic [15:0]    ctl_q;
    logic [15:0]    rdata_q;
    logic [7:0]     rxd_q;
    logic           rf_q;
    logic [31:0]    rf_cnt_q;
    fpcs_rf_state_t rf_state_q;
    fpcs_rf_state_t rf_state_d;
    logic           link_up;
    logic           blk_cext;
    logic           np_take;
    logic           ctl_wr;
    logic           rf_fast_en;
    logic           rf_std_en;
    logic           rf_armed;
    logic [31:0]    rf_limit;
    logic           rf_done;
    logic [15:0]    ext_cap;
    logic [15:0]    ctl_view;
    logic           crs_tx;
    logic           blk_cext_en;
    logic           crs_tx_en;
    logic           force_link;
    logic           lb_raw;
    logic           irq_active_low;

    // true when a strobe addresses one register
    function automatic logic fn_hit(
        input logic       strobe,
        input logic [4:0] addr,
        input logic [4:0] reg_addr
    );
        return strobe && (addr == reg_addr);
    endfunction

    // 1000BASE-X capability, absent only in mode 00
    function automatic logic fn_x_cap(
        input logic [1:0] mode
    );
        return mode != fpcs_pkg::MODE_100FX;
    endfunction

    // extended capability word for the current mode
    function automatic logic [15:0] fn_ext_cap(
        input logic [1:0] mode
    );
        logic [15:0] w;
        w = 16'h0000; // R4
        w[fpcs_pkg::EXT_X_FD] = fn_x_cap(mode); // R3
        w[fpcs_pkg::EXT_X_HD] = fn_x_cap(mode); // R3
        return w;
    endfunction

    // control word as read back, mode field from outside
    function automatic logic [15:0] fn_ctl_view(
        input logic [15:0] ctl,
        input logic [1:0]  mode
    );
        return {ctl[15:2], mode};
    endfunction

    // stored control bits, mode field not writable
    function automatic logic [15:0] fn_ctl_write(
        input logic [15:0] wdata
    );
        return wdata & fpcs_pkg::CTL_WR_MASK;
    endfunction

    // received code word fields, loaded one to one
    function automatic logic [15:0] fn_np_map(
        input logic [15:0] cw
    );
        logic        next_page;
        logic        ack;
        logic        msg_page;
        logic        second_ack_flag;
        logic        toggle;
        logic [10:0] msg_field;
        {next_page, ack, msg_page, second_ack_flag, toggle, msg_field} = cw;
        return {next_page, ack, msg_page, second_ack_flag, toggle, msg_field};
    endfunction

    // read data for one address, zero when unmapped
    function automatic logic [15:0] fn_read_mux(
        input logic [4:0]  addr,
        input logic [15:0] np,
        input logic [15:0] ext,
        input logic [15:0] ctl
    );
        logic [15:0] d;
        case (addr)
            fpcs_pkg::ADDR_NP_WORD: begin
                d = np;
            end
            fpcs_pkg::ADDR_EXT_CAP: begin
                d = ext;
            end
            fpcs_pkg::ADDR_LINK_CTRL: begin
                d = ctl;
            end
            default: begin
                d = 16'h0000;
            end
        endcase
        return d;
    endfunction

    // remote fault delay, fast enable takes priority
    function automatic logic [31:0] fn_rf_limit(
        input logic fast
    );
        logic [31:0] lim;
        if (fast) begin
            lim = 32'(RF_FAST_CYCLES);
        end else begin
            lim = 32'(RF_STD_CYCLES);
        end
        return lim;
    endfunction

    // next remote fault state
    function automatic fpcs_rf_state_t fn_rf_next(
        input fpcs_rf_state_t state,
        input logic           armed,
        input logic           done
    );
        fpcs_rf_state_t nxt;
        nxt = FPCS_RF_IDLE;
        case (state)
            FPCS_RF_IDLE: begin
                if (armed && done) begin
                    nxt = FPCS_RF_SEND;
                end else if (armed) begin
                    nxt = FPCS_RF_COUNT;
                end else begin
                    nxt = FPCS_RF_IDLE;
                end
            end
            FPCS_RF_COUNT: begin
                if (!armed) begin
                    nxt = FPCS_RF_IDLE;
                end else if (done) begin
                    nxt = FPCS_RF_SEND;
                end else begin
                    nxt = FPCS_RF_COUNT;
                end
            end
            FPCS_RF_SEND: begin
                if (!armed) begin
                    nxt = FPCS_RF_IDLE;
                end else begin
                    nxt = FPCS_RF_SEND;
                end
            end
            default: begin
                nxt = FPCS_RF_IDLE;
            end
        endcase
        return nxt;
    endfunction

    // receive byte after carrier extension blocking
    function automatic logic [7:0] fn_rxd_next(
        input logic       blocked,
        input logic [7:0] rxd
    );
        logic [7:0] b;
        if (blocked) begin
            b = fpcs_pkg::RXD_IDLE;
        end else begin
            b = rxd;
        end
        return b;
    endfunction

    // interrupt pin level, polarity bit 1 means active low
    function automatic logic fn_irq_pin(
        input logic active_low,
        input logic event_in
    );
        logic pin;
        if (active_low) begin
            pin = !event_in;
        end else begin
            pin = event_in;
        end
        return pin;
    endfunction

    // control fields
    assign blk_cext_en    = ctl_q[fpcs_pkg::CTL_BLK_CEXT];
    assign crs_tx_en      = ctl_q[fpcs_pkg::CTL_CRS_TX];
    assign force_link     = ctl_q[fpcs_pkg::CTL_FORCE_LINK];
    assign lb_raw         = ctl_q[fpcs_pkg::CTL_LB_TYPE];
    assign irq_active_low = ctl_q[fpcs_pkg::CTL_INT_POL];

    // link, receive and fault conditions
    assign link_up    = force_link | LINK_RAW_UP; // R7
    assign blk_cext   = blk_cext_en & FULL_DUPLEX & RX_CEXT; // R5
    assign np_take    = AN_NP_VALID && (FIBER_MODE == fpcs_pkg::MODE_1000X); // R1 R15
    assign ctl_wr     = fn_hit(REG_WR, REG_ADDR, fpcs_pkg::ADDR_LINK_CTRL);
    assign rf_fast_en = ctl_q[fpcs_pkg::CTL_RF_FAST];
    assign rf_std_en  = ctl_q[fpcs_pkg::CTL_RF_STD];
    assign rf_armed   = RX_FAULT && (rf_fast_en || rf_std_en);
    assign rf_limit   = fn_rf_limit(rf_fast_en); // R9 R10
    assign rf_done    = rf_cnt_q >= (rf_limit - 32'h0000_0001);
    assign crs_tx     = TX_ACTIVE & crs_tx_en & !FULL_DUPLEX; // R6

    // read views and next fault state
    always_comb begin
        ext_cap    = fn_ext_cap(FIBER_MODE); // R3 R4
        ctl_view   = fn_ctl_view(ctl_q, FIBER_MODE); // R13
        rf_state_d = fn_rf_next(rf_state_q, rf_armed, rf_done);
    end

    // next-page capture, cleared while the link is down
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            np_q <= 16'h0000;
        end else if (!link_up) begin
            np_q <= 16'h0000; // R1
        end else if (np_take) begin
            np_q <= fn_np_map(AN_NP_WORD); // R2 R15
        end
    end

    // control register, bits 1:0 not stored
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            ctl_q <= fpcs_pkg::CTL_RESET; // R12
        end else if (ctl_wr) begin
            ctl_q <= fn_ctl_write(REG_WDATA);
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            rdata_q <= 16'h0000;
        end else if (REG_RD) begin
            rdata_q <= fn_read_mux(REG_ADDR, np_q, ext_cap, ctl_view);
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    // receive data with carrier extension blocking
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            rxd_q <= fpcs_pkg::RXD_IDLE;
        end else begin
            rxd_q <= fn_rxd_next(blk_cext, RXD_IN); // R5
        end
    end

    // remote fault delay counter
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            rf_cnt_q <= 32'h0000_0000;
        end else if (!rf_armed) begin
            rf_cnt_q <= 32'h0000_0000;
        end else if (!rf_done) begin
            rf_cnt_q <= rf_cnt_q + 32'h0000_0001;
        end
    end

    // remote fault state
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            rf_state_q <= FPCS_RF_IDLE;
        end else begin
            rf_state_q <= rf_state_d;
        end
    end

    // remote fault indication to the partner
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            rf_q <= 1'b0;
        end else begin
            rf_q <= (rf_state_d == FPCS_RF_SEND); // R9 R10
        end
    end

    // outputs
    assign REG_RDATA       = rdata_q;
    assign RXD_OUT         = rxd_q;
    assign CRS_OUT         = RX_ACTIVE | crs_tx; // R6
    assign LINK_UP         = link_up; // R7
    assign LOOPBACK_RAW    = lb_raw; // R8
    assign REMOTE_FAULT_TX = rf_q;
    assign IRQ_OUT_N       = fn_irq_pin(irq_active_low, IRQ_EVENT); // R12
endmodule
`default_nettype wire

// ===== verification/fpcs_lp.sv
// link partner model: next pages and raw link state
`timescale 1ns/10ps
`default_nettype none
module fpcs_lp (
    input  wire logic        SYS_CLK,
    output logic             AN_NP_VALID,
    output logic      [15:0] AN_NP_WORD,
    output logic             LINK_RAW_UP
);
    initial {AN_NP_VALID, AN_NP_WORD, LINK_RAW_UP} = {1'b0, 16'h5a5a, 1'b1};
    task automatic send(input logic [15:0] w);
        @(posedge SYS_CLK);
        AN_NP_VALID <= 1'b1;
        AN_NP_WORD  <= w;
        @(posedge SYS_CLK);
        AN_NP_VALID <= 1'b0;
        AN_NP_WORD  <= ~w;
    endtask
    task automatic link(input logic v);
        @(posedge SYS_CLK);
        LINK_RAW_UP <= v;
    endtask
endmodule
`default_nettype wire

// ===== verification/fpcs_props.sv
// checker of the fiber pcs register block
`timescale 1ns/10ps
`default_nettype none
module fpcs_props (
    input wire logic        SYS_CLK, NRST, REG_RD, AN_NP_VALID, LINK_UP, LINK_RAW_UP,
    input wire logic        FULL_DUPLEX, RX_ACTIVE, CRS_OUT, RX_CEXT, RX_FAULT,
    input wire logic        REMOTE_FAULT_TX,
    input wire logic [4:0]  REG_ADDR,
    input wire logic [1:0]  FIBER_MODE,
    input wire logic [7:0]  RXD_IN, RXD_OUT,
    input wire logic [15:0] REG_RDATA, AN_NP_WORD
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    wire logic np = REG_RD && REG_ADDR == fpcs_pkg::ADDR_NP_WORD;
    wire logic ex = REG_RD && REG_ADDR == fpcs_pkg::ADDR_EXT_CAP;
    wire logic ct = REG_RD && REG_ADDR == fpcs_pkg::ADDR_LINK_CTRL;
    property p_ext; ex |=> REG_RDATA == {{2{$past(FIBER_MODE) != 2'h0}}, 14'h0}; endproperty
    a_ext: assert property (p_ext) else $error("ext bits");
    property p_mode; ct |=> REG_RDATA[1:0] == $past(FIBER_MODE); endproperty
    a_mode: assert property (p_mode) else $error("mode field");
    property p_clr; !LINK_UP ##1 !AN_NP_VALID ##1 np |=> REG_RDATA == 16'h0; endproperty
    a_clr: assert property (p_clr) else $error("np clear");
    property p_load; AN_NP_VALID && LINK_UP && FIBER_MODE == fpcs_pkg::MODE_1000X
        ##1 LINK_UP && !AN_NP_VALID ##1 LINK_UP && np |=> REG_RDATA == $past(AN_NP_WORD, 3);
    endproperty
    a_load: assert property (p_load) else $error("np load");
    property p_link; LINK_RAW_UP |-> LINK_UP; endproperty
    a_link: assert property (p_link) else $error("link");
    property p_rxd; !RX_CEXT |=> RXD_OUT == $past(RXD_IN); endproperty
    a_rxd: assert property (p_rxd) else $error("rxd");
    property p_crs; FULL_DUPLEX |-> CRS_OUT == RX_ACTIVE; endproperty
    a_crs: assert property (p_crs) else $error("crs");
    property p_rf; !RX_FAULT |=> !REMOTE_FAULT_TX; endproperty
    a_rf: assert property (p_rf) else $error("fault");
    c_np: cover property (AN_NP_VALID && LINK_UP);
    c_rf: cover property ($rose(REMOTE_FAULT_TX));
    c_cx: cover property (FULL_DUPLEX && RX_CEXT);
endmodule
bind fpcs_regs fpcs_props i_props (.*);
`default_nettype wire

// ===== verification/tb_top.sv
// testbench of the fiber pcs register block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic SYS_CLK = 0, NRST = 0, REG_WR = 0, REG_RD = 0, FULL_DUPLEX = 0, TX_ACTIVE = 0;
    logic RX_ACTIVE = 0, RX_CEXT = 0, RX_FAULT = 0, IRQ_EVENT = 0, CRS_OUT, LINK_UP;
    logic LOOPBACK_RAW, REMOTE_FAULT_TX, IRQ_OUT_N, AN_NP_VALID, LINK_RAW_UP;
    logic [1:0] FIBER_MODE = 2'h1;
    logic [4:0] REG_ADDR = 5'h00;
    logic [7:0] RXD_IN = 8'h00, RXD_OUT;
    logic [15:0] REG_WDATA = 16'h0000, REG_RDATA, AN_NP_WORD, w;
    int failures = 0, n_checks = 0;
    fpcs_regs #(.RF_FAST_CYCLES(20), .RF_STD_CYCLES(200)) i_dut (.*);
    fpcs_lp i_lp (.*);
    initial forever #5 SYS_CLK = ~SYS_CLK;
    task automatic chk(input logic [15:0] g, e);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [15:0] d);
        @(posedge SYS_CLK);
        REG_ADDR <= fpcs_pkg::ADDR_LINK_CTRL;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge SYS_CLK);
        REG_WR <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        @(posedge SYS_CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge SYS_CLK);
        REG_RD <= 1'b0;
        #1 chk(REG_RDATA, e);
    endtask
    task automatic rf(input logic [15:0] d, input int lo, hi);
        int n;
        wr(d);
        RX_FAULT <= 1'b1;
        n = 0;
        while (REMOTE_FAULT_TX !== 1'b1 && n < 300) begin
            @(posedge SYS_CLK);
            #1 n++;
        end
        chk(16'(n >= lo && n <= hi), 16'h1);
        RX_FAULT <= 1'b0;
    endtask
    task automatic close_out;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        void'($urandom(13681));
        repeat (8) @(posedge SYS_CLK);
        NRST <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            FIBER_MODE <= 2'(m);
            rd(fpcs_pkg::ADDR_EXT_CAP, {{2{m != 0}}, 14'h0});
            rd(fpcs_pkg::ADDR_LINK_CTRL, fpcs_pkg::CTL_RESET | 16'(m));
        end
        rd(5'h1f, 16'h0000);
        $display("register test done");
        FIBER_MODE <= fpcs_pkg::MODE_1000X;
        w = 16'($urandom);
        i_lp.send(w);
        rd(fpcs_pkg::ADDR_NP_WORD, w);
        i_lp.link(1'b0);
        i_lp.link(1'b1);
        rd(fpcs_pkg::ADDR_NP_WORD, 16'h0000);
        $display("next page test done");
        wr(16'h6d2c);
        rd(fpcs_pkg::ADDR_LINK_CTRL, 16'h6d2d);
        chk(LOOPBACK_RAW, 16'h1);
        IRQ_EVENT <= 1'b1;
        TX_ACTIVE <= 1'b1;
        i_lp.link(1'b0);
        #1 chk({IRQ_OUT_N, CRS_OUT, LINK_UP}, 16'h3);
        FULL_DUPLEX <= 1'b1;
        RX_CEXT <= 1'b1;
        RXD_IN <= 8'($urandom) | 8'h01;
        @(posedge SYS_CLK);
        #1 chk({CRS_OUT, RXD_OUT}, 16'h0);
        RX_CEXT <= 1'b0;
        @(posedge SYS_CLK);
        #1 chk(RXD_OUT, RXD_IN);
        i_lp.link(1'b1);
        rf(16'h4028, 19, 22);
        rf(16'h4018, 198, 202);
        RX_ACTIVE <= 1'b1;
        #1 chk({IRQ_OUT_N, CRS_OUT}, 16'h3);
        $display("control test done");
        close_out();
    end
    initial begin
        #100000;
        failures++;
        close_out();
    end
endmodule
`default_nettype wire
